/* File: logic/smn_core.sv */
`timescale 1ns/1ps
module smn_core
  import smn_pkg::*;
#(
  parameter int CONV_SHORT = CONV_SHORT_CYC,
  parameter int CONV_LONG  = CONV_LONG_CYC,
  parameter int RST_PULSE  = RESET_PULSE_CYC,
  parameter int PWM_PERIOD = PWM_PERIOD_CYC
)(
  input  wire logic                     mclk_i,          // 25 MHz clock
  input  wire logic                     rst_n_i,         // Sync reset, active low
  input  wire logic                     monitor_en_i,    // Start monitoring
  input  wire logic                     rd2_analog_i,    // Diode 2 as two voltages
  input  wire logic [DW-1:0]            adc_data_i,      // Converter result
  output logic      [SLOT_W-1:0]        adc_chan_o,      // Channel converting
  output logic                          adc_long_o,      // Long conversion
  output logic                          adc_sample_o,    // Result taken
  input  wire logic [NUM_SLOT*DW-1:0]   lim_hi_i,        // High limits
  input  wire logic [NUM_SLOT*DW-1:0]   lim_lo_i,        // Low limits
  input  wire logic [NUM_FAN*DW-1:0]    fan_lim_i,       // Fan count limits
  input  wire logic [NUM_FAN*FDIV_W-1:0] fan_div_i,      // Fan divisors
  output logic      [NUM_SLOT*DW-1:0]   values_o,        // Value registers
  output logic      [NUM_FAN*DW-1:0]    fan_count_o,     // Fan counts
  output logic      [NUM_STAT-1:0]      status_o,        // Event flags
  input  wire logic [NUM_STAT-1:0]      stat_clr_i,      // Flag clear pulses
  input  wire logic [NUM_STAT-1:0]      mask_i,          // Flag masks
  output logic                          int_o,           // Interrupt, high
  input  wire logic [6:0]               host_addr_i,     // Bus slave address
  output logic                          addr_hit_o,      // Address matches
  input  wire logic [PTR_W-1:0]         host_byte_i,     // Written byte
  input  wire logic                     host_byte_vld_i, // Byte strobe
  input  wire logic                     host_first_i,    // First byte of write
  output logic      [PTR_W-1:0]         addr_ptr_o,      // Address pointer
  output logic      [DW-1:0]            rd_data_o,       // Selected register
  input  wire logic                     chassis_intrusion_in_i, // Intrusion pin
  input  wire logic                     chassis_clr_i,   // Clear intrusion bit
  output logic                          chassis_o,       // Intrusion latched
  input  wire logic                     main_low_i,      // Main supply low
  input  wire logic                     stby_low_i,      // Standby supply low
  input  wire logic                     main_rail_reset_i,    // Pin level
  output logic                          main_rail_reset_o,    // Pin out value
  output logic                          main_rail_reset_oe_o, // Pin drive
  output logic                          standby_rail_reset_n_o, // Stby reset
  input  wire logic [DW-1:0]            pwm_duty_i,      // PWM duty
  output logic                          pwm_o,           // PWM pin value
  output logic                          pwm_oe_o,        // PWM pin drive
  input  wire logic                     dac_wr_i,        // DAC code strobe
  input  wire logic [DW-1:0]            dac_wdata_i,     // DAC code
  output logic      [DW-1:0]            dac_code_o,      // Code to DAC
  input  wire logic [NUM_GPIO-1:0]      pin_i,           // GPIO and tach pins
  output logic      [NUM_GPIO-1:0]      pin_o,           // Pin out values
  output logic      [NUM_GPIO-1:0]      pin_oe_o,        // Pin drives
  input  wire logic [NUM_FAN-1:0]       fan_gpio_i,      // Tach pin as GPIO
  input  wire logic [NUM_GPIO-1:0]      gpio_dir_i,      // 1 is output
  input  wire logic [NUM_GPIO-1:0]      gpio_pol_i,      // 1 inverts
  input  wire logic [NUM_GPIO-1:0]      gpio_out_i,      // Output values
  output logic      [NUM_GPIO-1:0]      gpio_in_o,       // Input values
  input  wire logic                     thermal_alert_pin_i,  // Pin level
  output logic                          thermal_alert_pin_o,  // Pin out value
  output logic                          thermal_alert_pin_oe_o, // Pin drive
  input  wire logic                     thermal_alert_pin_gpio_i,    // Pin as GPIO
  input  wire logic                     thermal_alert_pin_dir_i,     // GPIO direction
  input  wire logic                     thermal_alert_pin_pol_i,     // GPIO polarity
  input  wire logic                     thermal_alert_pin_out_i,     // GPIO out value
  output logic                          thermal_alert_pin_in_o       // GPIO in value
);
  smn_seq_t             state;
  logic [SLOT_W-1:0]    slot;
  logic [SLOT_W-1:0]    last_slot;
  logic [TIMER_W-1:0]   conv_cnt;
  logic [TIMER_W-1:0]   conv_last;
  logic [DW-1:0]        val [NUM_SLOT];
  logic [DW-1:0]        fan_cnt [NUM_FAN];
  logic [NUM_FAN-1:0]   fan_done;
  logic [NUM_STAT-1:0]  set_vec;
  logic                 slot_oor;
  logic [NUM_ASYNC-1:0] async_in;
  logic [NUM_ASYNC-1:0] sync1;
  logic [NUM_ASYNC-1:0] sync2;
  logic [NUM_GPIO-1:0]  pin_s;
  logic                 thermal_alert_pin_s;
  logic                 ci_s;
  logic                 main_low_s;
  logic                 stby_low_s;
  logic                 main_pin_s;
  logic                 core_rst_n;
  logic                 main_rst_n;
  logic [11:0]          fan_pre;
  logic                 fan_tick;
  logic [15:0]          pwm_cnt;
  logic [DW-1:0]        pwm_phase;
  logic                 temp_alert;
  logic [2:0]           thermal_alert_pin_drv;
  logic [PTR_W-1:0]     ptr_fan;

  assign async_in = {main_rail_reset_i, stby_low_i, main_low_i, chassis_intrusion_in_i,
                     thermal_alert_pin_i, pin_i};

  // Pins and supply detectors cross into the clock domain here
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  assign {main_pin_s, stby_low_s, main_low_s, ci_s, thermal_alert_pin_s, pin_s} = sync2;
  // Rail reset pin low, from us or from outside, holds the core
  assign core_rst_n = rst_n_i & main_pin_s;

  smn_rstgen #(.PULSE_CYC(RST_PULSE)) u_main_rst (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .fail_i  (main_low_s),
    .rst_n_o (main_rst_n)
  );

  smn_rstgen #(.PULSE_CYC(RST_PULSE)) u_stby_rst (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .fail_i  (stby_low_s),
    .rst_n_o (standby_rail_reset_n_o)
  );

  // Open drain: drive low only while the rail reset is asserted
  assign main_rail_reset_o    = main_rst_n;
  assign main_rail_reset_oe_o = ~main_rst_n;

  // Conversion sequencer
  assign last_slot  = rd2_analog_i ? SLOT_ALT : SLOT_EXT2;
  assign adc_chan_o = slot;
  assign adc_long_o = (slot == SLOT_EXT1) || (slot == SLOT_EXT2 && !rd2_analog_i);
  assign conv_last  = adc_long_o ? TIMER_W'(CONV_LONG - 1) : TIMER_W'(CONV_SHORT - 1);
  assign adc_sample_o = (state == SEQ_STORE);

  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      state    <= SEQ_IDLE;
      slot     <= SLOT_FIRST;
      conv_cnt <= '0;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          if (monitor_en_i) begin
            state    <= SEQ_CONV;
            slot     <= SLOT_FIRST;
            conv_cnt <= '0;
          end
        end
        SEQ_CONV: begin
          if (conv_cnt == conv_last) begin
            state <= SEQ_STORE;
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        SEQ_STORE: begin
          conv_cnt <= '0;
          slot     <= (slot == last_slot) ? SLOT_FIRST : slot + 1'b1;
          state    <= monitor_en_i ? SEQ_CONV : SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      for (int i = 0; i < NUM_SLOT; i++) begin
        val[i] <= DATA_ZERO;
      end
    end else if (state == SEQ_STORE) begin
      val[slot] <= adc_data_i;
    end
  end

  assign slot_oor = (adc_data_i > lim_hi_i[slot*DW +: DW]) ||
                    (adc_data_i < lim_lo_i[slot*DW +: DW]);

  // Fan base tick shared by all channels; divisors apply per fan
  always_ff @(posedge mclk_i) begin
    if (!core_rst_n || fan_tick) begin
      fan_pre <= '0;
    end else begin
      fan_pre <= fan_pre + 1'b1;
    end
  end
  assign fan_tick = (fan_pre == 12'(FAN_TICK_CYC - 1));

  for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
    smn_tach u_tach (
      .mclk_i  (mclk_i),
      .rst_n_i (core_rst_n),
      .en_i    (!fan_gpio_i[f]),
      .tach_i  (pin_s[NUM_PLAIN+f]),
      .tick_i  (fan_tick),
      .div_i   (fan_div_i[f*FDIV_W +: FDIV_W]),
      .count_o (fan_cnt[f]),
      .done_o  (fan_done[f])
    );
    assign fan_count_o[f*DW +: DW] = fan_cnt[f];
    // Slow fan shows as a count above its limit
    assign set_vec[STAT_FAN0+f] = fan_done[f] && (fan_cnt[f] > fan_lim_i[f*DW +: DW]);
  end

  for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
    assign values_o[s*DW +: DW] = val[s];
    assign set_vec[s] = (state == SEQ_STORE) && (slot == SLOT_W'(s)) && slot_oor;
  end

  // Ignore the pin for three cycles after our own drive ends
  assign set_vec[STAT_THERMAL_ALERT_PIN] = !thermal_alert_pin_gpio_i && !thermal_alert_pin_s && (thermal_alert_pin_drv == 3'h0);

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      status_o <= '0;
      int_o    <= 1'b0;
    end else begin
      status_o <= (status_o & ~stat_clr_i) | set_vec;
      int_o    <= |(status_o & ~mask_i);
    end
  end

  // Battery-backed bit: the core reset from the rail pin leaves it alone
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      chassis_o <= 1'b0;
    end else begin
      chassis_o <= (chassis_o & ~chassis_clr_i) | ci_s;
    end
  end

  // Host side: address match and pointer
  assign ptr_fan = addr_ptr_o - PTR_W'(NUM_SLOT);

  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      addr_ptr_o <= '0;
      rd_data_o  <= DATA_ZERO;
      addr_hit_o <= 1'b0;
    end else begin
      addr_hit_o <= (host_addr_i[6:2] == SLAVE_ADDR_HI);
      if (host_byte_vld_i && host_first_i) begin
        addr_ptr_o <= host_byte_i;
      end
      if (addr_ptr_o < PTR_W'(NUM_SLOT)) begin
        rd_data_o <= val[addr_ptr_o[SLOT_W-1:0]];
      end else if (addr_ptr_o < PTR_W'(NUM_SLOT + NUM_FAN)) begin
        rd_data_o <= fan_cnt[ptr_fan[2:0]];
      end else begin
        rd_data_o <= DATA_ZERO;
      end
    end
  end

  // PWM: 256 steps per period; the remainder of the division is dropped
  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      pwm_cnt   <= '0;
      pwm_phase <= DATA_ZERO;
      pwm_o     <= 1'b0;
    end else begin
      if (pwm_cnt == 16'(PWM_PERIOD / PWM_STEPS - 1)) begin
        pwm_cnt   <= '0;
        pwm_phase <= pwm_phase + 1'b1;
      end else begin
        pwm_cnt <= pwm_cnt + 1'b1;
      end
      pwm_o <= (pwm_phase < pwm_duty_i);
    end
  end
  assign pwm_oe_o = ~pwm_o;

  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      dac_code_o <= DATA_ZERO;
    end else if (dac_wr_i) begin
      dac_code_o <= dac_wdata_i;
    end
  end

  for (genvar g = 0; g < NUM_GPIO; g++) begin : g_gpio
    logic is_gpio;
    if (g < NUM_PLAIN) begin : g_plain
      assign is_gpio = 1'b1;
    end else begin : g_tach
      assign is_gpio = fan_gpio_i[g-NUM_PLAIN];
    end
    always_ff @(posedge mclk_i) begin
      if (!core_rst_n) begin
        gpio_in_o[g] <= 1'b0;
        pin_o[g]     <= 1'b0;
        pin_oe_o[g]  <= 1'b0;
      end else begin
        gpio_in_o[g] <= pin_s[g] ^ gpio_pol_i[g];
        pin_o[g]     <= gpio_out_i[g] ^ gpio_pol_i[g];
        pin_oe_o[g]  <= is_gpio & gpio_dir_i[g];
      end
    end
  end

  assign temp_alert = (status_o[SLOT_AMBIENT] & ~mask_i[SLOT_AMBIENT]) |
                      (status_o[SLOT_EXT1] & ~mask_i[SLOT_EXT1]) |
                      (status_o[SLOT_EXT2] & ~mask_i[SLOT_EXT2] & ~rd2_analog_i);

  always_ff @(posedge mclk_i) begin
    if (!core_rst_n) begin
      thermal_alert_pin_o    <= 1'b0;
      thermal_alert_pin_oe_o <= 1'b0;
      thermal_alert_pin_in_o             <= 1'b0;
      thermal_alert_pin_drv              <= 3'h0;
    end else begin
      thermal_alert_pin_o    <= thermal_alert_pin_gpio_i & (thermal_alert_pin_out_i ^ thermal_alert_pin_pol_i);
      thermal_alert_pin_oe_o <= thermal_alert_pin_gpio_i ? thermal_alert_pin_dir_i : temp_alert;
      thermal_alert_pin_in_o             <= thermal_alert_pin_s ^ thermal_alert_pin_pol_i;
      thermal_alert_pin_drv              <= {thermal_alert_pin_drv[1:0], thermal_alert_pin_oe_o};
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!core_rst_n);

  sequence store_s;
    state == SEQ_STORE;
  endsequence
  sequence restart_s;
    state == SEQ_CONV && conv_cnt == '0;
  endsequence

  seq_restart_a: assert property (store_s and monitor_en_i |=> restart_s)
    else $error("next conversion did not start after store");
  seq_advance_a: assert property (store_s and slot != last_slot |=>
    slot == $past(slot) + 1'b1)
    else $error("sequence did not step to next channel");
  seq_wrap_a: assert property (store_s and slot == last_slot |=> slot == SLOT_FIRST)
    else $error("sequence did not wrap");
  conv_time_a: assert property (store_s |-> $past(conv_cnt) == conv_last &&
    $past(state) == SEQ_CONV)
    else $error("conversion time wrong");
  value_store_a: assert property (store_s |=> val[$past(slot)] == $past(adc_data_i))
    else $error("result not stored");
  limit_flag_a: assert property (store_s and slot_oor |=> status_o[$past(slot)])
    else $error("out-of-limit flag not set");
  flag_hold_a: assert property (1'b1 |=>
    ((status_o & $past(status_o & ~stat_clr_i)) == $past(status_o & ~stat_clr_i)))
    else $error("flag dropped without clear");
  int_raise_a: assert property ((|(status_o & ~mask_i)) |=> int_o)
    else $error("interrupt not raised");
  int_quiet_a: assert property ((&mask_i) ##1 (&mask_i) |-> !int_o)
    else $error("masked source reached interrupt");
  chassis_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ci_s |=> chassis_o)
    else $error("intrusion not latched");
  ptr_load_a: assert property (host_byte_vld_i && host_first_i |=>
    addr_ptr_o == $past(host_byte_i))
    else $error("pointer not loaded");
  pwm_off_a: assert property (pwm_duty_i == DATA_ZERO |=> !pwm_o && pwm_oe_o)
    else $error("pwm high at zero duty");
endmodule // smn_core

/* File: logic/smn_pkg.sv */
package smn_pkg;
  localparam int CLK_HZ       = 25_000_000;
  localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int DW           = 8;
  localparam int NUM_SLOT     = 21;
  localparam int SLOT_W       = 5;
  localparam int NUM_FAN      = 8;
  localparam int NUM_GPIO     = 16;
  localparam int NUM_PLAIN    = 8;
  localparam int NUM_STAT     = NUM_SLOT + NUM_FAN + 1;
  localparam int STAT_FAN0    = NUM_SLOT;
  localparam int STAT_THERMAL_ALERT_PIN   = NUM_SLOT + NUM_FAN;
  localparam int PTR_W        = 8;
  localparam int TIMER_W      = 24;
  localparam int FDIV_W       = 2;
  localparam int NUM_ASYNC    = NUM_GPIO + 5;

  localparam logic [SLOT_W-1:0] SLOT_FIRST           = 5'h00;
  localparam logic [SLOT_W-1:0] CORE_VOLTAGE_CHANNEL = 5'h04;
  localparam logic [SLOT_W-1:0] SLOT_AMBIENT         = 5'h0d;
  localparam logic [SLOT_W-1:0] SLOT_STBY            = 5'h0e;
  localparam logic [SLOT_W-1:0] SLOT_EXT1            = 5'h12;
  localparam logic [SLOT_W-1:0] SLOT_EXT2            = 5'h13;
  localparam logic [SLOT_W-1:0] SLOT_ALT             = 5'h14;

  localparam logic [4:0]    SLAVE_ADDR_HI = 5'h0b;
  localparam logic [DW-1:0] DATA_ZERO     = 8'h00;
  localparam logic [DW-1:0] DATA_MAX      = 8'hff;

  localparam int CONV_SHORT_US   = 11380;
  localparam int CONV_LONG_US    = 34130;
  localparam int CONV_SHORT_CYC  = CONV_SHORT_US * CYC_PER_US;
  localparam int CONV_LONG_CYC   = CONV_LONG_US * CYC_PER_US;
  localparam int RESET_PULSE_MS  = 180;
  localparam int RESET_PULSE_CYC = RESET_PULSE_MS * 1000 * CYC_PER_US;
  localparam int PWM_HZ          = 75;
  localparam int PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ;
  localparam int PWM_STEPS       = 256;
  localparam int FAN_TICK_HZ     = 22500;
  localparam int FAN_TICK_CYC    = CLK_HZ / FAN_TICK_HZ;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_CONV  = 3'b010,
    SEQ_STORE = 3'b100
  } smn_seq_t;
endpackage

/* File: logic/smn_tach.sv */
`timescale 1ns/1ps
module smn_tach
  import smn_pkg::*;
(
  input  wire logic              mclk_i,   // System clock
  input  wire logic              rst_n_i,  // Sync reset, active low
  input  wire logic              en_i,     // Pin used as tach input
  input  wire logic              tach_i,   // Synchronised tach level
  input  wire logic              tick_i,   // Base count tick
  input  wire logic [FDIV_W-1:0] div_i,    // Prescale 1,2,4,8
  output logic      [DW-1:0]     count_o,  // Ticks per revolution
  output logic                   done_o    // New count pulse
);
  logic          prev;
  logic          arm;
  logic          half;
  logic [2:0]    pre;
  logic [DW-1:0] cnt;
  logic          rise;
  logic          ptick;

  assign rise  = tach_i & ~prev;
  assign ptick = tick_i && (pre == 3'((1 << div_i) - 1));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !en_i) begin
      pre <= '0;
    end else if (tick_i) begin
      pre <= ptick ? 3'h0 : pre + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prev    <= 1'b0;
      arm     <= 1'b0;
      half    <= 1'b0;
      cnt     <= DATA_ZERO;
      count_o <= DATA_MAX;
      done_o  <= 1'b0;
    end else begin
      prev   <= tach_i;
      done_o <= 1'b0;
      if (!en_i) begin
        arm <= 1'b0;
      end else if (rise) begin
        // Second edge after arming closes one revolution
        if (!arm) begin
          arm  <= 1'b1;
          half <= 1'b0;
          cnt  <= DATA_ZERO;
        end else if (half) begin
          count_o <= cnt;
          done_o  <= 1'b1;
          half    <= 1'b0;
          cnt     <= DATA_ZERO;
        end else begin
          half <= 1'b1;
        end
      end else if (ptick && arm) begin
        // A stalled fan reads full scale and disarms until the next edge
        if (cnt == DATA_MAX) begin
          count_o <= DATA_MAX;
          done_o  <= 1'b1;
          arm     <= 1'b0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  rev_done_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (en_i && rise && arm && half) |=> (done_o && count_o == $past(cnt)))
    else $error("tach count not stored after two pulses");
endmodule // smn_tach

/* File: logic/smn_rstgen.sv */
`timescale 1ns/1ps
module smn_rstgen
  import smn_pkg::*;
#(
  parameter int PULSE_CYC = RESET_PULSE_CYC
)(
  input  wire logic mclk_i,   // System clock
  input  wire logic rst_n_i,  // Power-on reset, active low
  input  wire logic fail_i,   // Supply below threshold
  output logic      rst_n_o   // Rail reset, active low
);
  logic [TIMER_W-1:0] cnt;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || fail_i) begin
      cnt     <= '0;
      rst_n_o <= 1'b0;
    end else if (cnt != TIMER_W'(PULSE_CYC - 1)) begin
      cnt     <= cnt + 1'b1;
      rst_n_o <= 1'b0;
    end else begin
      rst_n_o <= 1'b1;
    end
  end

  fail_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fail_i |=> !rst_n_o)
    else $error("rail reset not asserted on low supply");
  pulse_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_o) |-> $past(cnt) == TIMER_W'(PULSE_CYC - 1))
    else $error("rail reset released early");
endmodule // smn_rstgen

/* File: tb/smn_host.sv */
`timescale 1ns/1ps
module smn_host
  import smn_pkg::*;
(
  input  wire logic             mclk_i,  // System clock
  output logic      [PTR_W-1:0] byte_o,  // Byte to device
  output logic                  vld_o,   // Byte strobe
  output logic                  first_o  // First byte of write
);
  initial begin
    byte_o  = DATA_ZERO;
    vld_o   = 1'b0;
    first_o = 1'b0;
  end
  // Address byte then one data byte; released bus shows the inverse
  task automatic write2(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] d);
    @(posedge mclk_i);
    byte_o  <= a;
    vld_o   <= 1'b1;
    first_o <= 1'b1;
    @(posedge mclk_i);
    byte_o  <= d;
    first_o <= 1'b0;
    @(posedge mclk_i);
    byte_o  <= ~d;
    vld_o   <= 1'b0;
  endtask
endmodule // smn_host

/* File: tb/tb_smn_core.sv */
`timescale 1ns/1ps
module tb_smn_core;
  import smn_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, en = 0, stby = 0, ci = 0, ext_n = 1, tach = 0;
  logic dac_wr = 0, rd2 = 0, cclr = 0, mlow = 0, tgpio = 0;
  logic [DW-1:0] dac_d = 8'h00, adc_d = 8'h80, duty = 8'h40;
  logic [NUM_SLOT*DW-1:0] lim_hi = {{20{8'hff}}, 8'h70}, lim_lo = '0;
  logic [NUM_FAN*DW-1:0] fan_lim = '1;
  logic [NUM_FAN*FDIV_W-1:0] fan_div = '0;
  logic [NUM_STAT-1:0] clr = '0, msk = '0;
  logic [6:0] haddr = 7'h2e;
  logic [NUM_FAN-1:0] fgpio = 8'h00;
  logic [NUM_GPIO-1:0] gdir = 16'h0002, gpol = 16'h0001, gout = 16'h0002, pins;
  assign pins = {7'h7f, tach, 8'h00};
  logic [PTR_W-1:0] hb;
  logic hv, hf, mpin, tpin;
  logic [7:0] n_fail = 0;
  int comparisons = 0;
  wire logic [NUM_STAT-1:0] st;
  wire logic [DW-1:0] vals [NUM_SLOT];
  always #20 mclk_i = ~mclk_i;
  always #160 tach = ~tach;
  assign mpin = ~u_smn_core.main_rail_reset_oe_o & ext_n;
  assign tpin = u_smn_core.thermal_alert_pin_oe_o ? u_smn_core.thermal_alert_pin_o : 1'b1;
  smn_host u_smn_host (.mclk_i(mclk_i), .byte_o(hb), .vld_o(hv), .first_o(hf));
  smn_core #(.CONV_SHORT(8), .CONV_LONG(20), .RST_PULSE(16), .PWM_PERIOD(512)) u_smn_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .monitor_en_i(en), .rd2_analog_i(rd2),
    .adc_data_i(adc_d), .adc_chan_o(), .adc_long_o(), .adc_sample_o(),
    .lim_hi_i(lim_hi), .lim_lo_i(lim_lo),
    .fan_lim_i(fan_lim), .fan_div_i(fan_div), .values_o(),
    .fan_count_o(), .status_o(st), .stat_clr_i(clr), .mask_i(msk),
    .int_o(), .host_addr_i(haddr), .addr_hit_o(), .host_byte_i(hb),
    .host_byte_vld_i(hv), .host_first_i(hf), .addr_ptr_o(), .rd_data_o(),
    .chassis_intrusion_in_i(ci), .chassis_clr_i(cclr), .chassis_o(), .main_low_i(mlow),
    .stby_low_i(stby), .main_rail_reset_i(mpin), .main_rail_reset_o(),
    .main_rail_reset_oe_o(), .standby_rail_reset_n_o(), .pwm_duty_i(duty), .pwm_o(),
    .pwm_oe_o(), .dac_wr_i(dac_wr), .dac_wdata_i(dac_d), .dac_code_o(),
    .pin_i(pins), .pin_o(), .pin_oe_o(), .fan_gpio_i(fgpio),
    .gpio_dir_i(gdir), .gpio_pol_i(gpol), .gpio_out_i(gout), .gpio_in_o(),
    .thermal_alert_pin_i(tpin), .thermal_alert_pin_o(), .thermal_alert_pin_oe_o(),
    .thermal_alert_pin_gpio_i(tgpio), .thermal_alert_pin_dir_i(1'b0), .thermal_alert_pin_pol_i(1'b0), .thermal_alert_pin_out_i(1'b0),
    .thermal_alert_pin_in_o());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Each slot is its conversion plus one store cycle
  task automatic seq_check;
    int n;
    logic [4:0] c;
    for (int i = 0; i < 21; i++) begin
      n = 1;
      while (u_smn_core.adc_sample_o !== 1'b1 && n < 100) begin
        cyc(1);
        n++;
      end
      c = 5'(i % 20);
      chk(u_smn_core.adc_chan_o, c, "slot order");
      chk(u_smn_core.adc_long_o, c > 17, "long slot");
      if (i > 0) chk(n, c > 17 ? 21 : 9, "slot length");
      cyc(1);
    end
  endtask
  initial begin
    cyc(3);
    rst_n_i <= 1'b1;
    cyc(5);
    chk(u_smn_core.standby_rail_reset_n_o, 0, "stby hold");
    cyc(30);
    chk(u_smn_core.standby_rail_reset_n_o, 1, "stby end");
    chk(u_smn_core.addr_hit_o, 1, "slave address");
    en <= 1'b1;
    seq_check();
    chk(u_smn_core.values_o[SLOT_AMBIENT*8+:8], 8'h80, "ambient value");
    chk(st[0], 1, "flag set");
    chk(u_smn_core.int_o, 1, "int set");
    lim_hi[DW-1:0] <= 8'hff;
    cyc(250);
    chk(st[0], 1, "flag sticky");
    msk[0] <= 1'b1;
    cyc(3);
    chk(u_smn_core.int_o, 0, "masked");
    clr[0] <= 1'b1;
    cyc(1);
    clr[0] <= 1'b0;
    cyc(2);
    chk(st[0], 0, "flag clear");
    u_smn_host.write2(SLOT_STBY, 8'h55);
    cyc(3);
    chk(u_smn_core.addr_ptr_o, SLOT_STBY, "pointer");
    chk(u_smn_core.rd_data_o, 8'h80, "stby value");
    ext_n <= 1'b0;
    cyc(4);
    ext_n <= 1'b1;
    cyc(10);
    chk(u_smn_core.addr_ptr_o, 8'h00, "pin reset");
    ci <= 1'b1;
    cyc(1);
    ci <= 1'b0;
    cyc(4);
    chk(u_smn_core.chassis_o, 1, "intrusion");
    stby <= 1'b1;
    cyc(5);
    chk(u_smn_core.standby_rail_reset_n_o, 0, "stby low");
    stby <= 1'b0;
    cyc(10);
    chk(u_smn_core.standby_rail_reset_n_o, 0, "stby pulse");
    dac_wr <= 1'b1;
    dac_d <= 8'h5a;
    cyc(1);
    dac_wr <= 1'b0;
    cyc(20);
    chk(u_smn_core.dac_code_o, 8'h5a, "dac");
    chk(u_smn_core.standby_rail_reset_n_o, 1, "stby back");
    chk(u_smn_core.gpio_in_o[1:0], 2'b01, "gpio in");
    chk(u_smn_core.pin_oe_o[1:0], 2'b10, "gpio dir");
    chk(u_smn_core.fan_count_o[7:0] < 8'h02, 1, "fan count");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    final_report();
  end
endmodule // tb_smn_core
